// ==== tmrp_read_port.sv ====
`timescale 1ns/100ps

// ----------------------------------------------------------------------
// Message queue.
// ----------------------------------------------------------------------
module tmrp_fifo #(
    parameter int WIDTH = 80,
    parameter int DEPTH = 16,
    localparam int AW = $clog2(DEPTH),
    localparam int CW = $clog2(DEPTH + 1)
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    output logic [CW-1:0] count_o
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic ready_q;
    wire push_w = in_valid_i && ready_q;
    wire pop_w = out_valid_o && out_ready_i;

    // Steps a storage pointer around the ring.
    function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
        step = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction

    // Occupancy and flags; ready is kept in a flop so full is exact.
    assign cnt_d = CW'(cnt_q + CW'(push_w) - CW'(pop_w));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o = mem_q[rd_ptr_q];
    assign in_ready_o = ready_q;
    assign count_o = cnt_q;

    // Storage write.
    always_ff @(posedge clk_i)
        if (push_w)
            mem_q[wr_ptr_q] <= in_data_i;

    // Pointer and occupancy update.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q <= '0;
            ready_q <= 1'b0;
        end
        else
        begin
            wr_ptr_q <= push_w ? step(wr_ptr_q) : wr_ptr_q;
            rd_ptr_q <= pop_w ? step(rd_ptr_q) : rd_ptr_q;
            cnt_q <= cnt_d;
            ready_q <= (cnt_d != CW'(DEPTH));
        end
    end
endmodule

// ----------------------------------------------------------------------
// Read port.
// ----------------------------------------------------------------------
// Operation
// - Pointer returns to its read-start value on read NACK or STOP.
// - Pointer advances after every memory byte read; count and message reads load the message object base.
// - Continuous message reads wrap the pointer to the message object base.
// - A read inside the message object range returns a whole message.
// - Message is report identifier then nine payload bytes.
// - Checksum mode appends an 8-bit CRC over identifier and payload.
// - Encryption pads each block, CRC included, out to 16 bytes.
// - High address byte top bit set requests a CRC on each message.
// - Reading at the count object first returns pending message count.
// - No START or STOP between messages; STOP ends and resets pointer.
// - NACK before the final STOP returns pointer to count object; here it returns to the read-start value, which may lie elsewhere.
// - Active-low open-drain attention line asserts while messages pend.
// - Attention line has two selectable modes.
// - Edge mode releases after first identifier ack, reasserts at STOP if pending.
// - Level mode holds while messages remain, releases after last identifier ack.
// - Identifier 255 means no valid message.
module tmrp_read_port
    import tmrp_pkg::*;
#(
    parameter int FIFO_DEPTH = 16,
    parameter int MSG_OBJ_SIZE = 11,
    parameter logic [BYTE_W-1:0] CRC_POLY = 8'h07,
    localparam int CW = $clog2(FIFO_DEPTH + 1)
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire tmrp_bus_ev_type bus_ev_i,
    input wire logic wr_valid_i,
    input wire logic [BYTE_W-1:0] wr_byte_i,
    output logic tx_valid_o,
    output logic [BYTE_W-1:0] tx_byte_o,
    output logic [ADDR_W-1:0] mem_addr_o,
    input wire logic [BYTE_W-1:0] mem_data_i,
    input wire logic msg_valid_i,
    input wire tmrp_msg_type msg_i,
    output logic msg_ready_o,
    input wire logic [ADDR_W-1:0] msg_base_i,
    input wire logic [ADDR_W-1:0] count_addr_i,
    input wire logic encrypt_en_i,
    input wire tmrp_att_mode_type att_mode_i,
    output logic [CW-1:0] pending_o,
    output logic [ADDR_W-1:0] ptr_o,
    output logic crc_mode_o,
    input wire logic host_attention_line_i,
    output logic host_attention_line_o,
    output logic host_attention_line_oe_o
);
    tmrp_rd_state_type state_q;
    logic [ADDR_W-1:0] ptr_q;
    logic [ADDR_W-1:0] start_ptr_q;
    logic [ADDR_W-1:0] mem_addr_q;
    logic [IDX_W-1:0] idx_q;
    logic [1:0] wr_idx_q;
    logic crc_mode_q;
    logic in_read_q;
    logic id_sent_q;
    logic rel_q;
    logic att_q;
    logic line_q;
    logic tx_valid_q;
    logic [BYTE_W-1:0] tx_byte_q;
    tmrp_msg_type cur_msg_q;
    logic [$bits(tmrp_msg_type)-1:0] head_raw;
    logic head_valid;
    logic [CW-1:0] pend_cnt;
    logic pop_w;

    // Picks byte idx of a message, identifier first.
    function automatic logic [BYTE_W-1:0] msg_byte(input tmrp_msg_type m,
                                                  input logic [IDX_W-1:0] idx);
        msg_byte = BYTE_W'(m >> ((MSG_BYTES - 1 - int'(idx)) * BYTE_W));
    endfunction

    // Bitwise CRC over identifier and payload, most significant bit first.
    function automatic logic [BYTE_W-1:0] crc8(input tmrp_msg_type m);
        logic [BYTE_W-1:0] c;
        c = CRC_INIT;
        for (int i = $bits(tmrp_msg_type) - 1; i >= 0; i--)
            c = {c[BYTE_W-2:0], 1'b0} ^ ((c[BYTE_W-1] ^ m[i]) ? CRC_POLY : '0);
        crc8 = c;
    endfunction

    // ------------------------------------------------------------------
    // Message queue; a stalled source sees msg_ready_o low.
    // ------------------------------------------------------------------
    tmrp_fifo #(
        .WIDTH($bits(tmrp_msg_type)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(msg_valid_i),
        .in_ready_o(msg_ready_o),
        .in_data_i(msg_i),
        .out_valid_o(head_valid),
        .out_ready_i(pop_w),
        .out_data_o(head_raw),
        .count_o(pend_cnt)
    );

    // ------------------------------------------------------------------
    // Address decode and byte selection.
    // ------------------------------------------------------------------
    wire tmrp_msg_type head_w = tmrp_msg_type'(head_raw);
    wire tmrp_msg_type invalid_w = '{report_id: INVALID_ID, payload: '0};
    wire fetch_w = (state_q == RD_FETCH);
    wire idx0_w = (idx_q == ID_IDX);
    wire in_msg_w = ({1'b0, ptr_q} >= {1'b0, msg_base_i}) &&
                    ({1'b0, ptr_q} < ({1'b0, msg_base_i} + 16'(MSG_OBJ_SIZE)));
    wire at_count_w = (ptr_q == count_addr_i) && idx0_w;
    wire stream_w = !at_count_w && (in_msg_w || !idx0_w);
    wire mem_sel_w = !at_count_w && !stream_w;
    wire [IDX_W-1:0] last_idx_w = encrypt_en_i ? ENC_LAST_IDX :
                                  (crc_mode_q ? CRC_LAST_IDX : PLAIN_LAST_IDX);
    wire tmrp_msg_type cur_w = !idx0_w ? cur_msg_q : (head_valid ? head_w : invalid_w);
    wire [BYTE_W-1:0] stream_byte_w =
        (idx_q < IDX_W'(MSG_BYTES)) ? msg_byte(cur_w, idx_q) :
        ((idx_q == CRC_IDX) && crc_mode_q) ? crc8(cur_msg_q) : PAD_BYTE;
    wire [BYTE_W-1:0] out_byte_w = at_count_w ? BYTE_W'(pend_cnt) :
                                   (stream_w ? stream_byte_w : mem_data_i);
    assign pop_w = fetch_w && stream_w && idx0_w && head_valid;
    wire restore_w = in_read_q && (bus_ev_i.nack || bus_ev_i.stop);
    wire id_ack_w = bus_ev_i.ack && id_sent_q;
    wire upd_ok_w = !restore_w && !wr_valid_i;

    // Attention line next state for both modes.
    wire rel_d = bus_ev_i.stop ? 1'b0 : (rel_q || id_ack_w);
    wire att_edge_d = (pend_cnt != '0) && !rel_d;
    wire att_level_d = (pend_cnt != '0) || (att_q && !id_ack_w);
    wire att_d = (att_mode_i == ATT_LEVEL) ? att_level_d : att_edge_d;

    assign tx_valid_o = tx_valid_q;
    assign tx_byte_o = tx_byte_q;
    assign mem_addr_o = mem_addr_q;
    assign pending_o = pend_cnt;
    assign ptr_o = ptr_q;
    assign crc_mode_o = crc_mode_q;
    assign host_attention_line_o = line_q;
    assign host_attention_line_oe_o = att_q;

    // ------------------------------------------------------------------
    // Transaction tracking and byte request sequencing.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_q <= RD_IDLE;
            in_read_q <= 1'b0;
            start_ptr_q <= PTR_RESET;
            mem_addr_q <= PTR_RESET;
            wr_idx_q <= WR_LO;
            tx_valid_q <= 1'b0;
            tx_byte_q <= PAD_BYTE;
        end
        else
        begin
            tx_valid_q <= fetch_w;
            tx_byte_q <= fetch_w ? out_byte_w : tx_byte_q;
            unique case (state_q)
                RD_IDLE:
                    if (bus_ev_i.req && in_read_q)
                    begin
                        state_q <= RD_FETCH;
                        mem_addr_q <= ptr_q;
                    end
                RD_FETCH:
                    state_q <= RD_IDLE;
            endcase
            if (bus_ev_i.start)
            begin
                in_read_q <= bus_ev_i.read;
                wr_idx_q <= WR_LO;
                start_ptr_q <= bus_ev_i.read ? ptr_q : start_ptr_q;
            end
            else if (bus_ev_i.stop)
                in_read_q <= 1'b0;
            else if (wr_valid_i && (wr_idx_q != WR_DONE))
                wr_idx_q <= 2'(wr_idx_q + 1'b1);
        end
    end

    // ------------------------------------------------------------------
    // Address pointer, checksum flag and message position.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ptr_q <= PTR_RESET;
            crc_mode_q <= 1'b0;
            idx_q <= ID_IDX;
            cur_msg_q <= '0;
        end
        else if (wr_valid_i && (wr_idx_q == WR_LO))
            ptr_q[BYTE_W-1:0] <= wr_byte_i;
        else if (wr_valid_i && (wr_idx_q == WR_HI))
        begin
            ptr_q[ADDR_W-1:BYTE_W] <= wr_byte_i[CRC_FLAG_BIT-1:0];
            crc_mode_q <= wr_byte_i[CRC_FLAG_BIT];
        end
        else if (restore_w)
        begin
            ptr_q <= start_ptr_q;
            idx_q <= ID_IDX;
        end
        else if (fetch_w)
        begin
            ptr_q <= mem_sel_w ? ADDR_W'(ptr_q + 1'b1) : msg_base_i;
            if (stream_w)
            begin
                idx_q <= (idx_q == last_idx_w) ? ID_IDX : IDX_W'(idx_q + 1'b1);
                cur_msg_q <= idx0_w ? cur_w : cur_msg_q;
            end
        end
    end

    // ------------------------------------------------------------------
    // Attention line.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            id_sent_q <= 1'b0;
            rel_q <= 1'b0;
            att_q <= 1'b0;
            line_q <= 1'b0;
        end
        else
        begin
            id_sent_q <= fetch_w ? (stream_w && idx0_w) :
                         ((bus_ev_i.ack || bus_ev_i.nack) ? 1'b0 : id_sent_q);
            rel_q <= rel_d;
            att_q <= att_d;
            line_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_ptr_restore_start: assert property (
        restore_w && !wr_valid_i |=> ptr_q == $past(start_ptr_q) && idx_q == ID_IDX)
        else $error("Pointer not restored after NACK or STOP.");
    a_ptr_advance_one: assert property (
        fetch_w && mem_sel_w && upd_ok_w |=> ptr_q == ADDR_W'($past(ptr_q) + 1'b1))
        else $error("Pointer did not advance by one.");
    a_msg_wrap_base: assert property (
        fetch_w && stream_w && upd_ok_w && idx_q == last_idx_w
        |=> idx_q == ID_IDX && ptr_q == $past(msg_base_i))
        else $error("Message end did not wrap to base.");
    a_mid_msg_full: assert property (
        state_q == RD_IDLE && bus_ev_i.req && in_read_q && in_msg_w && ptr_q != msg_base_i
        && idx0_w && head_valid && ptr_q != count_addr_i && !restore_w && !wr_valid_i
        |-> ##2 tx_valid_o && tx_byte_o == $past(head_w.report_id, 2))
        else $error("Mid-object read did not start a whole message.");
    a_crc_byte_value: assert property (
        fetch_w && stream_w && idx_q == CRC_IDX && crc_mode_q
        |=> tx_byte_o == crc8($past(cur_msg_q)))
        else $error("Checksum byte wrong.");
    a_enc_block_len: assert property (
        fetch_w && stream_w && upd_ok_w && encrypt_en_i && idx_q == CRC_IDX
        |=> idx_q == IDX_W'(CRC_IDX + 1'b1))
        else $error("Encrypted block ended before 16 bytes.");
    a_count_first_byte: assert property (
        fetch_w && at_count_w |=> tx_valid_o && tx_byte_o == BYTE_W'($past(pend_cnt)))
        else $error("Count object byte is not the pending count.");
    a_att_edge_release: assert property (
        att_mode_i == ATT_EDGE && id_ack_w && !bus_ev_i.stop |=> !host_attention_line_oe_o)
        else $error("Edge mode did not release after identifier ack.");
    a_att_level_hold: assert property (
        att_mode_i == ATT_LEVEL && pend_cnt != '0 |=> host_attention_line_oe_o)
        else $error("Level mode released while messages remain.");
    a_invalid_id_byte: assert property (
        fetch_w && stream_w && idx0_w && !head_valid |=> tx_byte_o == INVALID_ID)
        else $error("Empty queue did not give identifier 255.");

    c_msg_wrap: cover property (fetch_w && stream_w && idx_q == last_idx_w);
    c_count_then_msg: cover property (fetch_w && at_count_w ##[1:40] pop_w);
    c_crc_read: cover property (pop_w && crc_mode_q);
    c_line_low: cover property (att_q && !host_attention_line_i);
endmodule

// ==== tmrp_pkg.sv ====
package tmrp_pkg;

    // ------------------------------------------------------------------
    // Widths and byte positions.
    // ------------------------------------------------------------------
    localparam int ADDR_W = 15;
    localparam int BYTE_W = 8;
    localparam int IDX_W = 5;
    localparam int MSG_BYTES = 10;
    localparam int CRC_FLAG_BIT = 7;

    // ------------------------------------------------------------------
    // Positions inside a message block.
    // ------------------------------------------------------------------
    localparam logic [IDX_W-1:0] ID_IDX = 5'h00;
    localparam logic [IDX_W-1:0] CRC_IDX = 5'h0a;
    localparam logic [IDX_W-1:0] PLAIN_LAST_IDX = 5'h09;
    localparam logic [IDX_W-1:0] CRC_LAST_IDX = 5'h0a;
    localparam logic [IDX_W-1:0] ENC_LAST_IDX = 5'h0f;

    // ------------------------------------------------------------------
    // Fixed byte values and reset values.
    // ------------------------------------------------------------------
    localparam logic [BYTE_W-1:0] INVALID_ID = 8'hff;
    localparam logic [BYTE_W-1:0] PAD_BYTE = 8'h00;
    localparam logic [BYTE_W-1:0] CRC_INIT = 8'h00;
    localparam logic [ADDR_W-1:0] PTR_RESET = 15'h0000;

    // ------------------------------------------------------------------
    // Pointer-write byte counter values.
    // ------------------------------------------------------------------
    localparam logic [1:0] WR_LO = 2'h0;
    localparam logic [1:0] WR_HI = 2'h1;
    localparam logic [1:0] WR_DONE = 2'h2;

    // ------------------------------------------------------------------
    // Types.
    // ------------------------------------------------------------------
    typedef enum logic {ATT_EDGE, ATT_LEVEL} tmrp_att_mode_type;

    typedef enum logic {RD_IDLE, RD_FETCH} tmrp_rd_state_type;

    typedef struct packed {
        logic [BYTE_W-1:0] report_id;
        logic [71:0] payload;
    } tmrp_msg_type;

    typedef struct packed {
        logic start;
        logic read;
        logic stop;
        logic ack;
        logic nack;
        logic req;
    } tmrp_bus_ev_type;

endpackage

// ==== tmrp_host_model.sv ====
`timescale 1ns/100ps

// ----------------------------------------------------------------------
// Host controller model at byte level.
// ----------------------------------------------------------------------
module tmrp_host_model
    import tmrp_pkg::*;
(
    input wire logic clk_i,
    input wire logic tx_valid_i,
    input wire logic [BYTE_W-1:0] tx_byte_i,
    input wire logic host_attention_line_i,
    output tmrp_bus_ev_type ev_o,
    output logic wr_valid_o,
    output logic [BYTE_W-1:0] wr_byte_o
);
    // Idle bus: no events, write data shows junk rather than a held value.
    initial
    begin
        ev_o = '0;
        wr_valid_o = 1'b0;
        wr_byte_o = 8'h00;
    end

    // Pulses one event for a single cycle; bits are start,read,stop,ack,nack,req.
    task automatic pulse(input logic [5:0] e);
        @(negedge clk_i);
        ev_o = tmrp_bus_ev_type'(e);
        @(negedge clk_i);
        ev_o = '0;
    endtask

    // Sends one written byte, then scrambles the released data.
    task automatic wr(input logic [7:0] b);
        @(negedge clk_i);
        wr_valid_o = 1'b1;
        wr_byte_o = b;
        @(negedge clk_i);
        wr_valid_o = 1'b0;
        wr_byte_o = ~b;
    endtask

    // Loads the pointer in its own write transaction, low byte first.
    task automatic wr_ptr(input logic [15:0] a);
        pulse(6'h20);
        wr(a[7:0]);
        wr(a[15:8]);
        pulse(6'h08);
    endtask

    // Opens a read transaction.
    task automatic rd_start();
        pulse(6'h30);
    endtask

    // Ends a transaction; callers read at least one byte first.
    task automatic stop();
        pulse(6'h08);
    endtask

    // Stalls, requests one byte, waits for it, then acks or nacks it.
    task automatic rd_byte(input int gap, input logic last, output logic [7:0] b);
        repeat (gap) @(negedge clk_i);
        pulse(6'h01);
        for (int i = 0; i < 6 && tx_valid_i !== 1'b1; i++)
            @(negedge clk_i);
        b = tx_byte_i;
        pulse(last ? 6'h02 : 6'h04);
    endtask
endmodule

// ==== tb_tmrp.sv ====
`timescale 1ns/100ps

// ----------------------------------------------------------------------
// Testbench.
// ----------------------------------------------------------------------
module tb;
    import tmrp_pkg::*;
    localparam logic [ADDR_W-1:0] CNT_A = 15'h0100;
    localparam logic [ADDR_W-1:0] MSG_A = 15'h0200;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic msg_valid = 1'b0;
    logic encrypt_en = 1'b0;
    tmrp_msg_type msg = '0;
    tmrp_att_mode_type att_mode = ATT_EDGE;
    tmrp_bus_ev_type bus_ev;
    logic wr_valid, tx_valid, msg_ready, crc_mode, line_o, line_oe, att_line;
    logic [BYTE_W-1:0] wr_byte, tx_byte, mem_data, b;
    logic [ADDR_W-1:0] mem_addr, ptr;
    logic [4:0] pending;
    int err_total = 0;
    int n_checks = 0;

    // Clock, pulled-up attention wire and a memory that reads a fixed pattern.
    always #5 clk_i = ~clk_i;
    assign att_line = line_oe ? line_o : 1'b1;
    assign mem_data = mem_addr[7:0] ^ 8'h5a;

    tmrp_read_port dut (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .bus_ev_i(bus_ev),
        .wr_valid_i(wr_valid),
        .wr_byte_i(wr_byte),
        .tx_valid_o(tx_valid),
        .tx_byte_o(tx_byte),
        .mem_addr_o(mem_addr),
        .mem_data_i(mem_data),
        .msg_valid_i(msg_valid),
        .msg_i(msg),
        .msg_ready_o(msg_ready),
        .msg_base_i(MSG_A),
        .count_addr_i(CNT_A),
        .encrypt_en_i(encrypt_en),
        .att_mode_i(att_mode),
        .pending_o(pending),
        .ptr_o(ptr),
        .crc_mode_o(crc_mode),
        .host_attention_line_i(att_line),
        .host_attention_line_o(line_o),
        .host_attention_line_oe_o(line_oe)
    );

    tmrp_host_model host (
        .clk_i(clk_i),
        .tx_valid_i(tx_valid),
        .tx_byte_i(tx_byte),
        .host_attention_line_i(att_line),
        .ev_o(bus_ev),
        .wr_valid_o(wr_valid),
        .wr_byte_o(wr_byte)
    );

    // Compares one value and counts it.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Message k: identifier 10h+k, payload bytes k*16+j, first byte highest.
    function automatic tmrp_msg_type mk(input int k);
        mk.report_id = 8'h10 + k[7:0];
        for (int j = 0; j < 9; j++)
            mk.payload[71 - 8 * j -: 8] = 8'(k * 16 + j);
    endfunction

    // Reference checksum over identifier and payload, most significant bit first.
    function automatic logic [7:0] crc8(input tmrp_msg_type m);
        logic [79:0] d;
        logic [7:0] c;
        d = m;
        c = CRC_INIT;
        for (int i = 79; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction

    // Offers message k to the queue for one cycle.
    task automatic push(input int k);
        @(negedge clk_i);
        msg_valid = 1'b1;
        msg = mk(k);
        @(negedge clk_i);
        msg_valid = 1'b0;
    endtask

    // Reads and checks one whole block; the attention wire is checked after the id.
    task automatic rd_msg(input int k, input logic crc, input logic last, input logic exp_att);
        tmrp_msg_type m;
        logic [7:0] e;
        int n;
        m = mk(k);
        n = encrypt_en ? 16 : (crc ? 11 : 10);
        for (int j = 0; j < n; j++)
        begin
            host.rd_byte(j % 3, last && j == n - 1, b);
            if (j == 0)
                e = m.report_id;
            else if (j < 10)
                e = m.payload[79 - 8 * j -: 8];
            else if (j == 10 && crc)
                e = crc8(m);
            else
                e = PAD_BYTE;
            chk(b, e);
            if (j == 0)
            begin
                @(negedge clk_i);
                chk(att_line, exp_att);
            end
        end
    endtask

    // Values right after reset.
    task automatic t_reset();
        chk(ptr, PTR_RESET);
        chk(pending, 5'h00);
        chk(line_oe, 1'b0);
        chk(msg_ready, 1'b1);
        chk(tx_valid, 1'b0);
    endtask

    // Plain memory read: pointer advances, then returns on NACK and STOP.
    task automatic t_plain();
        host.wr_ptr(16'h1234);
        chk(ptr, 15'h1234);
        chk(crc_mode, 1'b0);
        host.rd_start();
        for (int i = 0; i < 3; i++)
        begin
            host.rd_byte(i, i == 2, b);
            chk(b, (8'h34 + 8'(i)) ^ 8'h5a);
            if (i == 1)
                chk(ptr, 15'h1236);
        end
        host.stop();
        chk(ptr, 15'h1234);
    endtask

    // Edge mode with checksums over two continuous reads.
    task automatic t_edge();
        att_mode = ATT_EDGE;
        for (int k = 0; k < 3; k++)
            push(k);
        repeat (2) @(negedge clk_i);
        chk(att_line, 1'b0);
        host.wr_ptr({1'b1, CNT_A});
        chk(crc_mode, 1'b1);
        chk(ptr, CNT_A);
        host.rd_start();
        host.rd_byte(0, 1'b0, b);
        chk(b, 8'h03);
        rd_msg(0, 1'b1, 1'b1, 1'b1);
        chk(ptr, CNT_A);
        host.stop();
        repeat (2) @(negedge clk_i);
        chk(ptr, CNT_A);
        chk(att_line, 1'b0);
        host.rd_start();
        host.rd_byte(0, 1'b0, b);
        chk(b, 8'h02);
        rd_msg(1, 1'b1, 1'b0, 1'b1);
        rd_msg(2, 1'b1, 1'b0, 1'b1);
        host.rd_byte(0, 1'b1, b);
        chk(b, INVALID_ID);
        host.stop();
        repeat (2) @(negedge clk_i);
        chk(ptr, CNT_A);
        chk(att_line, 1'b1);
    endtask

    // Level mode, padded blocks, read started inside the message object.
    task automatic t_level();
        att_mode = ATT_LEVEL;
        encrypt_en = 1'b1;
        push(3);
        push(4);
        host.wr_ptr({1'b0, MSG_A + 15'h0003});
        host.rd_start();
        rd_msg(3, 1'b0, 1'b0, 1'b0);
        rd_msg(4, 1'b0, 1'b1, 1'b1);
        host.stop();
        chk(ptr, MSG_A + 15'h0003);
        encrypt_en = 1'b0;
    endtask

    // Fill the queue until it refuses, then drain it with a stalling host.
    task automatic t_fill();
        int nb;
        att_mode = ATT_EDGE;
        for (int k = 0; k < 16; k++)
            push(5 + k);
        chk(msg_ready, 1'b0);
        push(40);
        chk(pending, 5'h10);
        host.wr_ptr({1'b0, CNT_A});
        host.rd_start();
        host.rd_byte(1, 1'b0, b);
        chk(b, 8'h10);
        nb = b * (11 - 1);
        for (int k = 0; k < nb / 10; k++)
            rd_msg(5 + k, 1'b0, k == nb / 10 - 1, 1'b1);
        host.stop();
        repeat (2) @(negedge clk_i);
        chk(pending, 5'h00);
        chk(msg_ready, 1'b1);
        chk(att_line, 1'b1);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Main sequence after a 20-cycle reset.
    initial
    begin
        repeat (20) @(negedge clk_i);
        rst_i = 1'b0;
        @(negedge clk_i);
        t_reset();
        t_plain();
        t_edge();
        t_level();
        t_fill();
        test_done();
    end

    // Watchdog well beyond the expected run of about 1500 cycles.
    initial
    begin
        #400000;
        err_total++;
        test_done();
    end
endmodule
